// File: src/scl_defs.svh
// Contract
// (RULE1) Host writes base registers before any load
// (RULE2) Device fetches image alone after load request
// (RULE3) Host checks result, retries failed loads
// (RULE4) Memory select stays high during host setup
// (RULE5) Host puts device asleep before setup
// (RULE6) Offset 61 value 0d routes pin zero MOSI
// (RULE7) Offset 63 value 0c routes pin two clock
// (RULE8) Offset 64 value 80 selects pin one MISO
// (RULE9) Offset 60 value 05 makes pins outputs
// (RULE10) Start address: 24 bits at 58..5a
// (RULE11) Select goes low only after setup
// (RULE12) Done flag at 5b set on finish
// (RULE13) Error flag at 71, zero means success
// (RULE14) Read image in order, apply each entry
`ifndef SCL_DEFS_SVH
`define SCL_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SCL_OFS_SLEEP_A 8'h00
`define SCL_OFS_AUX 8'h48
`define SCL_OFS_ADDR2 8'h58
`define SCL_OFS_ADDR1 8'h59
`define SCL_OFS_ADDR0 8'h5A
`define SCL_OFS_DONE 8'h5B
`define SCL_OFS_DIR 8'h60
`define SCL_OFS_PIN0 8'h61
`define SCL_OFS_PIN2 8'h63
`define SCL_OFS_MISO 8'h64
`define SCL_OFS_ERR 8'h71
`define SCL_OFS_SLEEP_B 8'h7F

// ----------------------------------------
// Values, fields, timing
// ----------------------------------------
`define SCL_RST_BYTE 8'h00
`define SCL_SEL_MOSI 8'h0D
`define SCL_SEL_SCLK 8'h0C
`define SCL_SEL_MISO 8'h80
`define SCL_DIR_MASK 8'h05
`define SCL_CMD_READ 8'h03
`define SCL_END_MARK 8'hFF
`define SCL_HEAD_LAST 5'h1F
`define SCL_BYTE_LAST 5'h07
`define SCL_PIN_MOSI 0
`define SCL_PIN_MISO 1
`define SCL_PIN_SCLK 2
`define SCL_CLK_NS 4
`define SCL_SCLK_HALF_NS 32
`define SCL_MAX_ENTRIES 4096

`endif

// File: src/scl_pkg.sv
package scl_pkg;

   // Loader sequence, Gray along idle, header, read
   typedef enum logic [1:0] {
      SCL_IDLE = 2'h0,
      SCL_HEAD = 2'h1,
      SCL_READ = 2'h3
   } scl_state_e;

   typedef struct packed {
      scl_state_e st;
      logic [7:0] sleep_a;
      logic [7:0] aux;
      logic [7:0] addr2;
      logic [7:0] addr1;
      logic [7:0] addr0;
      logic [7:0] dir;
      logic [7:0] pin0_sel;
      logic [7:0] pin2_sel;
      logic [7:0] miso_sel;
      logic [7:0] sleep_b;
      logic done;
      logic err;
      logic [31:0] tx;
      logic [7:0] rx;
      logic [4:0] bits;
      logic [7:0] div;
      logic sclk;
      logic half;
      logic [7:0] ent_addr;
      logic pend;
      logic [15:0] entry;
      logic [15:0] count;
      logic [2:0] cs_sync;
      logic [1:0] miso_sync;
      logic [2:0] pin_out;
      logic [2:0] pin_oe_n;
      logic [7:0] rdata;
   } scl_state_s;

endpackage

// File: src/scl_loader.sv
`timescale 1ns/1ps
`include "scl_defs.svh"

// ----------------------------------------
// Entry FIFO between link and register side
// ----------------------------------------
module scl_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 32
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW:0] wp;
      logic [AW:0] rp;
   } scl_fifo_s;

   scl_fifo_s s;
   scl_fifo_s next_s;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push;
   logic pop;

   // Power-of-two depth keeps the wrap bit honest
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_fifo
      $error("scl_fifo: DEPTH must be a power of two");
   end

   // Full when pointers differ only in wrap bit
   assign in_ready = !((s.wp[AW] != s.rp[AW]) && (s.wp[AW-1:0] == s.rp[AW-1:0]));
   assign out_valid = (s.wp != s.rp);
   assign out_data = mem[s.rp[AW-1:0]];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // Pointer update
   always_comb begin
      next_s = s;
      if (push) begin
         next_s.wp = s.wp + 1'b1;
      end
      if (pop) begin
         next_s.rp = s.rp + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // Storage carries no reset; only pointers matter
   always_ff @(posedge clk) begin
      if (push) begin
         mem[s.wp[AW-1:0]] <= in_data;
      end
   end
endmodule

// ----------------------------------------
// Configuration loader, SPI master side
// ----------------------------------------
module scl_loader #(
   parameter int SCLK_HALF = (`SCL_SCLK_HALF_NS + `SCL_CLK_NS - 1) / `SCL_CLK_NS,
   parameter int MAX_ENTRIES = `SCL_MAX_ENTRIES,
   parameter int FIFO_DEPTH = 32
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic reg_wr,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic eeprom_cs_n,
   input wire logic [2:0] gpio_in,
   output logic [2:0] gpio_out,
   output logic [2:0] gpio_oe_n,
   output logic cfg_valid,
   input wire logic cfg_ready,
   output logic [7:0] cfg_addr,
   output logic [7:0] cfg_data,
   output logic load_busy
);
   localparam logic [7:0] HALF_M1 = 8'(SCLK_HALF - 1);
   localparam logic [15:0] MAX_M1 = 16'(MAX_ENTRIES - 1);

   scl_pkg::scl_state_s s;
   scl_pkg::scl_state_s next_s;
   logic fifo_in_ready;
   logic [15:0] fifo_out;
   logic route_ok;
   logic cs_fall;
   logic cs_high;
   logic edge_now;

   // Synced MISO must settle within a low phase
   if (SCLK_HALF < 3 || SCLK_HALF > 256) begin : g_bad_half
      $error("scl_loader: SCLK_HALF out of range");
   end
   if (MAX_ENTRIES < 1 || MAX_ENTRIES > 65536) begin : g_bad_max
      $error("scl_loader: MAX_ENTRIES out of range");
   end

   // ----------------------------------------
   // Register read decode
   // ----------------------------------------
   function automatic logic [7:0] read_reg(input scl_pkg::scl_state_s r,
                                           input logic [7:0] a);
      logic [7:0] v;
      v = `SCL_RST_BYTE;
      case (a)
         `SCL_OFS_SLEEP_A: v = r.sleep_a;
         `SCL_OFS_AUX: v = r.aux;
         `SCL_OFS_ADDR2: v = r.addr2;
         `SCL_OFS_ADDR1: v = r.addr1;
         `SCL_OFS_ADDR0: v = r.addr0;
         `SCL_OFS_DONE: v = {7'h00, r.done}; // RULE12
         `SCL_OFS_DIR: v = r.dir;
         `SCL_OFS_PIN0: v = r.pin0_sel;
         `SCL_OFS_PIN2: v = r.pin2_sel;
         `SCL_OFS_MISO: v = r.miso_sel;
         `SCL_OFS_ERR: v = {7'h00, r.err}; // RULE13
         `SCL_OFS_SLEEP_B: v = r.sleep_b;
         default: v = `SCL_RST_BYTE;
      endcase
      return v;
   endfunction

   // Pin routing; a partial setup blocks loads, yet pins zero and two each drive on their own direction bit and select
   assign route_ok = ((s.dir & `SCL_DIR_MASK) == `SCL_DIR_MASK) // RULE9
                  && (s.pin0_sel == `SCL_SEL_MOSI) // RULE6
                  && (s.pin2_sel == `SCL_SEL_SCLK) // RULE7
                  && (s.miso_sel == `SCL_SEL_MISO); // RULE8

   // Select edges seen on the second sync stage only
   assign cs_fall = s.cs_sync[2] && !s.cs_sync[1];
   assign cs_high = s.cs_sync[1];
   assign edge_now = (s.div == HALF_M1);

   // ----------------------------------------
   // Next-state logic
   // ----------------------------------------
   always_comb begin
      next_s = s;
      next_s.cs_sync = {s.cs_sync[1:0], eeprom_cs_n};
      next_s.miso_sync = {s.miso_sync[0], gpio_in[`SCL_PIN_MISO]};
      next_s.rdata = read_reg(s, reg_addr);

      // Host writes; status bytes are read-only
      if (reg_wr) begin
         case (reg_addr)
            `SCL_OFS_SLEEP_A: next_s.sleep_a = reg_wdata;
            `SCL_OFS_AUX: next_s.aux = reg_wdata;
            `SCL_OFS_ADDR2: next_s.addr2 = reg_wdata; // RULE10
            `SCL_OFS_ADDR1: next_s.addr1 = reg_wdata; // RULE10
            `SCL_OFS_ADDR0: next_s.addr0 = reg_wdata; // RULE10
            `SCL_OFS_DIR: next_s.dir = reg_wdata;
            `SCL_OFS_PIN0: next_s.pin0_sel = reg_wdata;
            `SCL_OFS_PIN2: next_s.pin2_sel = reg_wdata;
            `SCL_OFS_MISO: next_s.miso_sel = reg_wdata;
            `SCL_OFS_SLEEP_B: next_s.sleep_b = reg_wdata;
            default: next_s.rdata = next_s.rdata;
         endcase
      end

      // Entry waits here until the FIFO takes it
      if (s.pend && fifo_in_ready) begin
         next_s.pend = 1'b0;
      end

      unique case (s.st)
         scl_pkg::SCL_IDLE: begin
            next_s.sclk = 1'b0;
            next_s.div = 8'h00;
            if (cs_fall) begin
               // Falling select is the load request
               if (route_ok) begin // RULE11
                  next_s.done = 1'b0;
                  next_s.err = 1'b0;
                  next_s.tx = {`SCL_CMD_READ, s.addr2, s.addr1, s.addr0}; // RULE10
                  next_s.bits = 5'h00;
                  next_s.half = 1'b0;
                  next_s.count = 16'h0000;
                  next_s.st = scl_pkg::SCL_HEAD; // RULE2
               end else begin
                  next_s.done = 1'b1; // RULE12
                  next_s.err = 1'b1; // RULE13
               end
            end
         end
         scl_pkg::SCL_HEAD, scl_pkg::SCL_READ: begin
            if (cs_high) begin
               // Select released mid-image: abort as failure
               next_s.done = 1'b1; // RULE12
               next_s.err = 1'b1; // RULE13
               next_s.sclk = 1'b0;
               next_s.st = scl_pkg::SCL_IDLE;
            end else if (s.pend) begin
               // Clock paused low: back-pressure reaches the link
               next_s.div = s.div;
            end else if (!edge_now) begin
               next_s.div = s.div + 8'h01;
            end else begin
               next_s.div = 8'h00;
               next_s.sclk = !s.sclk;
               if (!s.sclk) begin
                  // Rising edge: sample MISO
                  next_s.rx = {s.rx[6:0], s.miso_sync[1]};
               end else begin
                  // Falling edge: shift MOSI, count bits
                  next_s.tx = {s.tx[30:0], 1'b0};
                  next_s.bits = s.bits + 5'h01;
                  if (s.st == scl_pkg::SCL_HEAD && s.bits == `SCL_HEAD_LAST) begin
                     next_s.bits = 5'h00;
                     next_s.st = scl_pkg::SCL_READ;
                  end
                  if (s.st == scl_pkg::SCL_READ && s.bits == `SCL_BYTE_LAST) begin
                     next_s.bits = 5'h00;
                     if (!s.half) begin
                        if (s.rx == `SCL_END_MARK) begin
                           next_s.done = 1'b1; // RULE12
                           next_s.st = scl_pkg::SCL_IDLE;
                        end else begin
                           next_s.ent_addr = s.rx;
                           next_s.half = 1'b1;
                        end
                     end else begin
                        // Address then value: one entry, in order
                        next_s.half = 1'b0;
                        next_s.entry = {s.ent_addr, s.rx}; // RULE14
                        next_s.pend = 1'b1; // RULE14
                        next_s.count = s.count + 16'h0001;
                        if (s.count == MAX_M1) begin
                           // Runaway image without end marker
                           next_s.done = 1'b1; // RULE12
                           next_s.err = 1'b1; // RULE13
                           next_s.st = scl_pkg::SCL_IDLE;
                        end
                     end
                  end
               end
            end
         end
         default: begin
            next_s.st = scl_pkg::SCL_IDLE;
         end
      endcase

      // Pins follow the registered clock and data
      next_s.pin_out = {next_s.sclk, 1'b0, next_s.tx[31]};
      next_s.pin_oe_n[`SCL_PIN_MOSI] = !(s.dir[`SCL_PIN_MOSI]
                                      && s.pin0_sel == `SCL_SEL_MOSI); // RULE6
      next_s.pin_oe_n[`SCL_PIN_MISO] = 1'b1; // RULE8
      next_s.pin_oe_n[`SCL_PIN_SCLK] = !(s.dir[`SCL_PIN_SCLK]
                                      && s.pin2_sel == `SCL_SEL_SCLK); // RULE7
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
         s.cs_sync <= 3'h7;
         s.pin_oe_n <= 3'h7;
      end else begin
         s <= next_s;
      end
   end

   // Entry buffer toward the register side
   scl_fifo #(
      .WIDTH(16),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .in_valid(s.pend),
      .in_ready(fifo_in_ready),
      .in_data(s.entry),
      .out_valid(cfg_valid),
      .out_ready(cfg_ready),
      .out_data(fifo_out)
   );

   assign cfg_addr = fifo_out[15:8];
   assign cfg_data = fifo_out[7:0];
   assign reg_rdata = s.rdata;
   assign gpio_out = s.pin_out;
   assign gpio_oe_n = s.pin_oe_n;
   assign load_busy = (s.st != scl_pkg::SCL_IDLE);
endmodule

// File: dv/scl_assertions.sv
`timescale 1ns/1ps
// ----------------------------------------
// Port checks for the loader
// ----------------------------------------
module scl_assertions #(
   parameter int SCLK_HALF = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic reg_wr,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic eeprom_cs_n,
   input wire logic [2:0] gpio_out,
   input wire logic [2:0] gpio_oe_n,
   input wire logic cfg_valid,
   input wire logic cfg_ready,
   input wire logic [7:0] cfg_addr,
   input wire logic [7:0] cfg_data,
   input wire logic load_busy
);
   logic [7:0] dir, p0, p2, hcnt;
   wire logic r0 = dir[0] && p0 == 8'h0D;
   wire logic r2 = dir[2] && p2 == 8'h0C;
   // Routing shadow from writes; clock high time counter
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dir <= 8'h00;
         p0 <= 8'h00;
         p2 <= 8'h00;
         hcnt <= 8'h00;
      end else begin
         if (reg_wr && reg_addr == 8'h60) dir <= reg_wdata;
         if (reg_wr && reg_addr == 8'h61) p0 <= reg_wdata;
         if (reg_wr && reg_addr == 8'h63) p2 <= reg_wdata;
         hcnt <= gpio_out[2] ? hcnt + 8'h01 : 8'h00;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Aborts cut a high phase short, so only steady frames are timed
   sequence s_steady_fall;
      (!eeprom_cs_n) [*6] ##0 $fell(gpio_out[2]);
   endsequence
   sequence s_done_polled;
      $fell(load_busy) ##1 reg_addr == 8'h5B;
   endsequence
   a_pin0_route: assert property ($stable(r0) |-> gpio_oe_n[0] == !r0)
      else $error("pin zero enable wrong");
   a_pin2_route: assert property ($stable(r2) |-> gpio_oe_n[2] == !r2)
      else $error("pin two enable wrong");
   a_pin1_input: assert property (gpio_oe_n[1] && !gpio_out[1])
      else $error("pin one driven");
   a_sclk_idle: assert property (!load_busy [*2] |-> !gpio_out[2])
      else $error("clock runs while idle");
   a_sclk_half: assert property (s_steady_fall |-> hcnt == 8'(SCLK_HALF))
      else $error("clock high phase wrong");
   a_start_cs: assert property ($rose(load_busy) |-> !eeprom_cs_n && !$past(eeprom_cs_n))
      else $error("load without select");
   a_cs_abort: assert property (load_busy && eeprom_cs_n |-> ##[1:8] !load_busy)
      else $error("no abort on deselect");
   a_done_flag: assert property (s_done_polled |=> reg_rdata == 8'h01)
      else $error("done flag not set");
   a_cfg_hold: assert property (cfg_valid && !cfg_ready |=>
      cfg_valid && $stable(cfg_addr) && $stable(cfg_data))
      else $error("entry changed while held");
endmodule

// File: dv/scl_eeprom_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Serial memory, mode 0, read only
// ----------------------------------------
module scl_eeprom_model (
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic mosi,
   output logic miso
);
   logic [7:0] mem [128];
   logic [31:0] hdr;
   int n;
   initial miso = 1'b0;
   // Each frame restarts the bit count
   always @(negedge cs_n) begin
      n = 0;
      hdr = 32'h00000000;
   end
   // Command and address shift in on rising edges
   always @(posedge sclk) begin
      if (!cs_n) begin
         if (n < 32) hdr = {hdr[30:0], mosi};
         n = n + 1;
      end
   end
   // Data moves on falling edges, address runs on in order
   always @(negedge sclk) begin
      if (!cs_n && n >= 32) miso = mem[(hdr[6:0] + (n - 32) / 8) % 128][7 - (n - 32) % 8];
   end
   // Released line must not keep a stale bit
   always @(posedge cs_n) miso = ~miso;
endmodule

// File: dv/scl_loader_test.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin \
   n_checks++; \
   if ((got) !== (exp)) begin \
      bad_count++; \
      $display("wrong value at %0t: got %0h, expected %0h", $time, got, exp); \
   end \
end
// ----------------------------------------
// Loader bench
// ----------------------------------------
module scl_loader_test;
   localparam int SCLK_HALF = 8;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic reg_wr = 1'b0;
   logic cs_n = 1'b1;
   logic cfg_ready = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata, cfg_addr, cfg_data;
   logic [2:0] gpio_out, gpio_oe_n, gpio_in;
   logic cfg_valid, load_busy, miso;
   int bad_count = 0;
   int n_checks = 0;
   int i, k, lo;
   logic [7:0] ta [7] = '{8'h00, 8'h7F, 8'h61, 8'h63, 8'h64, 8'h60, 8'h48};
   logic [7:0] tv [7] = '{8'h00, 8'h00, 8'h0D, 8'h0C, 8'h80, 8'h05, 8'h0C};
   // Undriven pins read low
   assign gpio_in = {gpio_oe_n[2] ? 1'b0 : gpio_out[2], miso, gpio_oe_n[0] ? 1'b0 : gpio_out[0]};
   always #2 clk = ~clk;
   scl_loader #(.SCLK_HALF(SCLK_HALF)) DUT (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .eeprom_cs_n(cs_n),
      .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n), .cfg_valid(cfg_valid),
      .cfg_ready(cfg_ready), .cfg_addr(cfg_addr), .cfg_data(cfg_data), .load_busy(load_busy));
   scl_eeprom_model mem_model (.cs_n(cs_n), .sclk(gpio_in[2]), .mosi(gpio_in[0]), .miso(miso));
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge clk);
      #1;
      reg_wr = 1'b0;
   endtask
   task automatic ck(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      #1;
      reg_addr = a;
      @(posedge clk);
      #1;
      `CHK(reg_rdata, e)
   endtask
   // Host polls done, then reads the error flag
   task automatic poll(input logic [7:0] e);
      i = 0;
      do begin
         @(posedge clk);
         #1;
         reg_addr = 8'h5B;
         @(posedge clk);
         #1;
         i++;
      end while (reg_rdata !== 8'h01 && i < 9000);
      `CHK(reg_rdata, 8'h01)
      ck(8'h71, e);
   endtask
   task automatic load(input logic [23:0] a);
      wr(8'h58, a[23:16]);
      wr(8'h59, a[15:8]);
      wr(8'h5A, a[7:0]);
      cs_n = 1'b0;
      repeat (6) @(posedge clk);
      #1;
   endtask
   task automatic put(input int b, input int n);
      for (k = 0; k < n; k++) begin
         mem_model.mem[b + 2 * k] = 8'(k);
         mem_model.mem[b + 2 * k + 1] = ~8'(k);
      end
      mem_model.mem[b + 2 * n] = 8'hFF;
   endtask
   task automatic take(input logic [7:0] a);
      for (i = 0; i < 2000 && cfg_valid !== 1'b1; i++) begin
         @(posedge clk);
         #1;
      end
      `CHK({cfg_addr, cfg_data}, {a, ~a})
      cfg_ready = 1'b1;
      @(posedge clk);
      #1;
      cfg_ready = 1'b0;
   endtask
   task automatic t_reset_and_bad_route;
      for (k = 0; k < 7; k++) ck(ta[k], 8'h00);
      `CHK(gpio_oe_n, 3'b111)
      wr(8'h60, 8'h05);
      load(24'h000000);
      poll(8'h01);
      `CHK(gpio_oe_n[2], 1'b1)
      cs_n = 1'b1;
   endtask
   task automatic t_setup;
      for (k = 0; k < 7; k++) wr(ta[k], tv[k]);
      wr(8'h5B, 8'h00);
      wr(8'h01, 8'hAA);
      for (k = 0; k < 7; k++) ck(ta[k], tv[k]);
      ck(8'h5B, 8'h01);
      ck(8'h01, 8'h00);
      `CHK(gpio_oe_n, 3'b010)
   endtask
   // Consumer stalls until the entry buffer refuses, then drains it
   task automatic t_full;
      put(16, 33);
      load(24'h000010);
      lo = 0;
      for (i = 0; i < 20000 && lo < 64; i++) begin
         @(posedge clk);
         #1;
         lo = gpio_out[2] ? 0 : lo + 1;
      end
      `CHK(load_busy, 1'b1)
      `CHK(mem_model.hdr, 32'h03000010)
      for (k = 0; k < 33; k++) take(8'(k));
      poll(8'h00);
      `CHK(cfg_valid, 1'b0)
      cs_n = 1'b1;
   endtask
   task automatic t_abort_retry;
      put(96, 3);
      load(24'h000060);
      repeat (700) @(posedge clk);
      #1;
      cs_n = 1'b1;
      poll(8'h01);
      `CHK(cfg_valid, 1'b0)
      load(24'h000060);
      for (k = 0; k < 3; k++) take(8'(k));
      poll(8'h00);
      cs_n = 1'b1;
   endtask
   task automatic stop_test;
      $display("checks %0d, errors %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (6) @(posedge clk);
      #1;
      rst_n = 1'b1;
      t_reset_and_bad_route();
      t_setup();
      t_full();
      t_abort_retry();
      stop_test();
   end
   // Hang guard, well beyond the expected run
   initial begin
      repeat (80000) @(posedge clk);
      bad_count++;
      stop_test();
   end
endmodule
bind scl_loader scl_assertions #(.SCLK_HALF(SCLK_HALF)) u_chk (.clk(clk), .rst_n(rst_n),
   .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .eeprom_cs_n(eeprom_cs_n), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n),
   .cfg_valid(cfg_valid), .cfg_ready(cfg_ready), .cfg_addr(cfg_addr), .cfg_data(cfg_data),
   .load_busy(load_busy));
